//--- common/cdb_pkg.sv
// Shared constants and types for the completion descriptor builder
package cdb_pkg;

  // Descriptor geometry
  localparam int DESC_W        = 96;
  localparam int FIFO_DEPTH    = 4;

  // Field positions inside the descriptor
  localparam int ERR_LSB       = 12;
  localparam int ERR_W         = 4;
  localparam int LOCKED_BIT    = 29;
  localparam int DONE_BIT      = 30;
  localparam int DW_CNT_LSB    = 32;
  localparam int DW_CNT_W      = 11;
  localparam int STATUS_LSB    = 43;
  localparam int STATUS_W      = 3;
  localparam int POISON_BIT    = 46;
  localparam int REQ_ID_LSB    = 48;
  localparam int ID_W          = 16;
  localparam int TAG_LSB       = 64;
  localparam int TAG_W         = 8;
  localparam int CMPL_ID_LSB   = 72;
  localparam int TC_LSB        = 89;
  localparam int TC_W          = 3;
  localparam int NO_SNOOP_BIT  = 92;
  localparam int RELAX_BIT     = 93;
  localparam int ID_ORDER_BIT  = 94;
  localparam int ATTR_W        = 3;
  localparam int BYTE_CNT_W    = 13;

  // Kind of request that the completion answers
  localparam logic [1:0] KIND_MEM_RD    = 2'h0;
  localparam logic [1:0] KIND_IO_RD     = 2'h1;
  localparam logic [1:0] KIND_IO_WR     = 2'h2;
  localparam logic [1:0] KIND_LOCKED_RD = 2'h3;

  // Completion status codes
  localparam logic [2:0] STS_SUCCESS = 3'h0;
  localparam logic [2:0] STS_UNSUPP  = 3'h1;
  localparam logic [2:0] STS_RETRY   = 3'h2;
  localparam logic [2:0] STS_ABORT   = 3'h4;

  // Error codes placed in the low descriptor word
  localparam logic [3:0] ERR_NORMAL  = 4'h0;
  localparam logic [3:0] ERR_POISON  = 4'h1;
  localparam logic [3:0] ERR_STATUS  = 4'h2;
  localparam logic [3:0] ERR_NO_DATA = 4'h3;
  localparam logic [3:0] ERR_TIMEOUT = 4'h9;

  // Fixed dword counts for the special completions
  localparam logic [10:0] DW_ONE  = 11'h001;
  localparam logic [10:0] DW_ZERO = 11'h000;

  // Reset values
  localparam logic        READY_RST = 1'b0;
  localparam logic [95:0] DESC_RST  = 96'h0;

  // Capture stage state, Gray along EMPTY -> LOADED
  typedef enum logic [0:0] {
    ST_EMPTY  = 1'b0,
    ST_LOADED = 1'b1
  } cdb_state_t;

endpackage : cdb_pkg

//--- core/cdb_fifo.sv
// Shift-register FIFO whose head entry is the output register
`timescale 1ns/10ps
`default_nettype none
module cdb_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  // Depth below two leaves no room to shift
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_param
    $error("cdb_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] data_r   [DEPTH];
  logic [WIDTH-1:0] data_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic             push;
  logic             pop;

  // Full is honest: no push while the last slot holds a word
  assign in_ready  = ~vld_r[DEPTH-1];
  assign out_valid = vld_r[0];
  assign out_data  = data_r[0];
  assign push      = in_valid & ~vld_r[DEPTH-1];
  assign pop       = vld_r[0] & out_ready;

  // Shift down on pop, then place the new word in the first free slot
  always_comb begin
    logic [DEPTH-1:0] vld_sh;
    vld_sh = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop) begin
        vld_sh[i]   = (i < DEPTH-1) ? vld_r[(i < DEPTH-1) ? i+1 : i] : 1'b0;
        data_nxt[i] = data_r[(i < DEPTH-1) ? i+1 : i];
      end else begin
        vld_sh[i]   = vld_r[i];
        data_nxt[i] = data_r[i];
      end
    end
    vld_nxt = vld_sh;
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !vld_sh[i] && (i == 0 || vld_sh[(i == 0) ? 0 : i-1])) begin
        vld_nxt[i]  = 1'b1;
        data_nxt[i] = in_data;
      end
    end
  end

  // Storage and occupancy flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vld_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        data_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        data_r[i] <= data_nxt[i];
      end
    end
  end

endmodule : cdb_fifo
`default_nettype wire

//--- core/cdb_builder.sv
// Completion descriptor builder: turns one received completion into a 96-bit descriptor
//
// Contract
// - Request-completed bit 30 set only on the final completion of a request
// - Request-completed set on normal end and on error end alike
// - Payload dword count in bits 42:32, eleven bits, 0 to 1K
// - I/O read completions report one dword, I/O write completions zero
// - Zero-length memory read completion reports one dword
// - Completion status copied into bits 45:43 with the standard codes
// - Bit 46 set when the received completion was poisoned
// - Requester identifier placed in bits 63:48
// - Tag placed in bits 71:64
// - Completer identifier copied into bits 87:72
// - Traffic class placed in bits 91:89
// - No-snoop bit 92, relaxed ordering bit 93, ID-based ordering bit 94
// - Timeout gives error code 1001 in 15:12; only done, requester, tag valid
// - Bit 29 set for locked read completions, clear otherwise
`timescale 1ns/10ps
`default_nettype none
module cdb_builder #(
  parameter int DEPTH = cdb_pkg::FIFO_DEPTH
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // Received completion, one per handshake
  input  wire logic        CPL_VALID,
  output logic             CPL_READY,
  input  wire logic        CPL_TIMEOUT,
  input  wire logic [1:0]  CPL_KIND,
  input  wire logic        CPL_ZERO_LEN,
  input  wire logic [2:0]  CPL_STATUS,
  input  wire logic        CPL_POISON,
  input  wire logic [15:0] CPL_REQ_ID,
  input  wire logic [7:0]  CPL_TAG,
  input  wire logic [15:0] CPL_CMPL_ID,
  input  wire logic [2:0]  CPL_TC,
  input  wire logic [2:0]  CPL_ATTR,
  input  wire logic [10:0] CPL_LEN_DW,
  input  wire logic [12:0] CPL_BYTE_COUNT,
  input  wire logic [1:0]  CPL_ADDR_LO,
  // Descriptor stream toward user logic
  output logic             DESC_VALID,
  input  wire logic        DESC_READY,
  output logic [95:0]      DESC_DATA
);

  // The output FIFO needs room for at least two words
  if (DEPTH < 2) begin : g_bad_depth
    $error("cdb_builder: DEPTH must be at least 2");
  end

  cdb_pkg::cdb_state_t state_r;
  cdb_pkg::cdb_state_t state_nxt;

  logic        ready_r;
  logic        ready_nxt;
  logic        accept;
  logic        push;
  logic        fifo_in_ready;

  // Captured completion fields
  logic        timeout_r;
  logic [1:0]  kind_r;
  logic        zero_len_r;
  logic [2:0]  status_r;
  logic        poison_r;
  logic [15:0] req_id_r;
  logic [7:0]  tag_r;
  logic [15:0] cmpl_id_r;
  logic [2:0]  tc_r;
  logic [2:0]  attr_r;
  logic [10:0] len_dw_r;
  logic [12:0] byte_cnt_r;
  logic [1:0]  addr_lo_r;

  // Derived descriptor fields
  logic        is_io;
  logic        is_locked;
  logic        bad_status;
  logic        no_data;
  logic [12:0] bytes_carried;
  logic        last_chunk;
  logic        done;
  logic [10:0] dw_count;
  logic [3:0]  err_code;
  logic [95:0] desc;

  assign accept = CPL_VALID & ready_r;
  assign push   = (state_r == cdb_pkg::ST_LOADED) & fifo_in_ready;

  // Capture stage: holds one completion until the FIFO takes its descriptor
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      cdb_pkg::ST_EMPTY: begin
        if (accept) begin
          state_nxt = cdb_pkg::ST_LOADED;
        end
      end
      cdb_pkg::ST_LOADED: begin
        if (push) begin
          state_nxt = cdb_pkg::ST_EMPTY;
        end
      end
      default: begin
        state_nxt = cdb_pkg::ST_EMPTY;
      end
    endcase
  end

  // Ready is a flop loaded from the next stage state, so after the first cycle out of reset it tracks the stage without lag; this halves
  // throughput but keeps the input port free of combinational paths
  assign ready_nxt = (state_nxt == cdb_pkg::ST_EMPTY);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= cdb_pkg::ST_EMPTY;
      ready_r <= cdb_pkg::READY_RST;
    end else begin
      state_r <= state_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign CPL_READY = ready_r;

  // Request identity, kept for every completion including a timeout
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      timeout_r <= 1'b0;
      req_id_r  <= 16'h0000;
      tag_r     <= 8'h00;
    end else if (accept) begin
      timeout_r <= CPL_TIMEOUT;
      req_id_r  <= CPL_REQ_ID;
      tag_r     <= CPL_TAG;
    end
  end

  // Header fields of the received completion packet
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      kind_r     <= cdb_pkg::KIND_MEM_RD;
      zero_len_r <= 1'b0;
      status_r   <= cdb_pkg::STS_SUCCESS;
      poison_r   <= 1'b0;
      cmpl_id_r  <= 16'h0000;
      tc_r       <= 3'h0;
      attr_r     <= 3'h0;
    end else if (accept) begin
      kind_r     <= CPL_KIND;
      zero_len_r <= CPL_ZERO_LEN;
      status_r   <= CPL_STATUS;
      poison_r   <= CPL_POISON;
      cmpl_id_r  <= CPL_CMPL_ID;
      tc_r       <= CPL_TC;
      attr_r     <= CPL_ATTR;
    end
  end

  // Sizing fields used to spot the final completion
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      len_dw_r   <= 11'h000;
      byte_cnt_r <= 13'h0000;
      addr_lo_r  <= 2'h0;
    end else if (accept) begin
      len_dw_r   <= CPL_LEN_DW;
      byte_cnt_r <= CPL_BYTE_COUNT;
      addr_lo_r  <= CPL_ADDR_LO;
    end
  end

  // Kind and error decode
  assign is_io      = (kind_r == cdb_pkg::KIND_IO_RD) | (kind_r == cdb_pkg::KIND_IO_WR);
  assign is_locked  = (kind_r == cdb_pkg::KIND_LOCKED_RD);
  assign bad_status = (status_r != cdb_pkg::STS_SUCCESS);
  assign no_data    = (len_dw_r == 11'h000) & ~is_io & ~zero_len_r;

  // Bytes this completion carries, less the skipped leading bytes
  assign bytes_carried = {len_dw_r, 2'b00} - {11'h000, addr_lo_r};
  assign last_chunk    = (byte_cnt_r <= bytes_carried);

  // Final completion: data exhausted, single-shot kinds, or any error end
  always_comb begin
    done = 1'b0;
    if (timeout_r) begin
      done = 1'b1;
    end else if (bad_status || no_data) begin
      done = 1'b1;
    end else if (is_io || zero_len_r) begin
      done = 1'b1;
    end else begin
      done = last_chunk;
    end
  end

  // Dword count: fixed for I/O and zero-length reads, else the packet length
  always_comb begin
    dw_count = len_dw_r;
    if (kind_r == cdb_pkg::KIND_IO_RD) begin
      dw_count = cdb_pkg::DW_ONE;
    end else if (kind_r == cdb_pkg::KIND_IO_WR) begin
      dw_count = cdb_pkg::DW_ZERO;
    end else if (zero_len_r) begin
      dw_count = cdb_pkg::DW_ONE;
    end
  end

  // Error code; timeout outranks everything since no packet arrived
  always_comb begin
    err_code = cdb_pkg::ERR_NORMAL;
    if (timeout_r) begin
      err_code = cdb_pkg::ERR_TIMEOUT;
    end else if (poison_r) begin
      err_code = cdb_pkg::ERR_POISON;
    end else if (bad_status) begin
      err_code = cdb_pkg::ERR_STATUS;
    end else if (no_data) begin
      err_code = cdb_pkg::ERR_NO_DATA;
    end
  end

  // Descriptor assembly; a timeout carries only error code, done, requester and tag
  always_comb begin
    desc = cdb_pkg::DESC_RST;
    desc[cdb_pkg::ERR_LSB +: cdb_pkg::ERR_W] = err_code;
    desc[cdb_pkg::DONE_BIT] = done;
    desc[cdb_pkg::REQ_ID_LSB +: cdb_pkg::ID_W] = req_id_r;
    desc[cdb_pkg::TAG_LSB +: cdb_pkg::TAG_W] = tag_r;
    if (!timeout_r) begin
      desc[cdb_pkg::LOCKED_BIT] = is_locked;
      desc[cdb_pkg::DW_CNT_LSB +: cdb_pkg::DW_CNT_W] = dw_count;
      desc[cdb_pkg::STATUS_LSB +: cdb_pkg::STATUS_W] = status_r;
      desc[cdb_pkg::POISON_BIT] = poison_r;
      desc[cdb_pkg::CMPL_ID_LSB +: cdb_pkg::ID_W] = cmpl_id_r;
      desc[cdb_pkg::TC_LSB +: cdb_pkg::TC_W] = tc_r;
      desc[cdb_pkg::NO_SNOOP_BIT] = attr_r[0];
      desc[cdb_pkg::RELAX_BIT] = attr_r[1];
      desc[cdb_pkg::ID_ORDER_BIT] = attr_r[2];
    end
  end

  // Output buffer; its head register drives the stream pins directly
  cdb_fifo #(
    .WIDTH (cdb_pkg::DESC_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_b     (RST_B),
    .in_valid  (state_r == cdb_pkg::ST_LOADED),
    .in_ready  (fifo_in_ready),
    .in_data   (desc),
    .out_valid (DESC_VALID),
    .out_ready (DESC_READY),
    .out_data  (DESC_DATA)
  );

endmodule : cdb_builder
`default_nettype wire

//--- verif/cdb_builder_assertions.sv
// Port-level concurrent checks for the completion descriptor builder
`timescale 1ns/10ps
`default_nettype none
module cdb_builder_assertions (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        CPL_VALID,
  input wire logic        CPL_READY,
  input wire logic        CPL_TIMEOUT,
  input wire logic [1:0]  CPL_KIND,
  input wire logic [2:0]  CPL_STATUS,
  input wire logic        CPL_POISON,
  input wire logic [15:0] CPL_REQ_ID,
  input wire logic [7:0]  CPL_TAG,
  input wire logic [15:0] CPL_CMPL_ID,
  input wire logic [2:0]  CPL_TC,
  input wire logic [2:0]  CPL_ATTR,
  input wire logic        DESC_VALID,
  input wire logic        DESC_READY,
  input wire logic [95:0] DESC_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic       tk;
  logic [3:0] ec;
  // Take into an empty path: the head shows it exactly two edges later
  assign tk = CPL_VALID && CPL_READY && !DESC_VALID && !CPL_TIMEOUT;
  assign ec = DESC_DATA[15:12];

  take_drop_a: assert property (CPL_VALID && CPL_READY |=> !CPL_READY)
    else $error("ready stayed high after a take");
  head_hold_a: assert property (DESC_VALID && !DESC_READY |=> DESC_VALID && $stable(DESC_DATA))
    else $error("descriptor moved while stalled");
  id_copy_a: assert property (tk |-> ##2 DESC_VALID && DESC_DATA[95:48] ==
    {1'b0, $past(CPL_ATTR, 2), $past(CPL_TC, 2), 1'b0, $past(CPL_CMPL_ID, 2),
     $past(CPL_TAG, 2), $past(CPL_REQ_ID, 2)}) else $error("identity fields wrong");
  status_copy_a: assert property (tk |-> ##2 DESC_DATA[46:43] ==
    {$past(CPL_POISON, 2), $past(CPL_STATUS, 2)}) else $error("status or poison wrong");
  lock_bit_a: assert property (tk |-> ##2 DESC_DATA[29] == ($past(CPL_KIND, 2) == 2'h3))
    else $error("locked bit wrong");
  io_count_a: assert property (tk && (CPL_KIND == 2'h1 || CPL_KIND == 2'h2) |-> ##2
    DESC_DATA[30] && DESC_DATA[42:32] == {10'h0, $past(CPL_KIND, 2) == 2'h1})
    else $error("io dword count wrong");
  spare_zero_a: assert property (DESC_VALID |-> !DESC_DATA[31] && !DESC_DATA[88] && !DESC_DATA[95])
    else $error("spare bit set");
  timeout_view_a: assert property (DESC_VALID && ec == 4'h9 |->
    {DESC_DATA[95:72], DESC_DATA[47:16]} == 56'h4000) else $error("timeout fields wrong");
  error_done_a: assert property (DESC_VALID && ec inside {4'h2, 4'h3, 4'h9} |-> DESC_DATA[30])
    else $error("error end without done");

  // Main scenarios: normal end, timeout, no-data end, back-pressure at both ports
  cover property (DESC_VALID && DESC_DATA[30] && ec == 4'h0);
  cover property (DESC_VALID && ec == 4'h9);
  cover property (DESC_VALID && ec == 4'h3);
  cover property (CPL_VALID && !CPL_READY && DESC_VALID && !DESC_READY);
endmodule : cdb_builder_assertions
bind cdb_builder cdb_builder_assertions chk_u (.*);
`default_nettype wire

//--- verif/cdb_user_model.sv
// User-side model that takes descriptors and tracks finished requests
`timescale 1ns/10ps
`default_nettype none
module cdb_user_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic        desc_valid,
  output logic             desc_ready,
  input  wire logic [95:0] desc_data
);
  logic [95:0] got_q[$];
  logic        ph_r = 1'h0;
  int          done_cnt = 0;
  int          bad_cnt = 0;
  // Completer identity as user logic splits it in both modes
  logic [7:0]  cid_bus;
  logic [4:0]  cid_dev;
  logic [2:0]  cid_fn;
  logic [7:0]  ari_fn;
  // Ready moves off the sampling edge; slow mode takes every other cycle
  always @(negedge clk) begin
    ph_r <= !ph_r;
    desc_ready <= rst_b && !stall && (!slow || ph_r);
  end
  // Done retires the request record; poisoned payload is counted as corrupt
  always @(posedge clk) begin
    if (desc_valid && desc_ready) begin
      got_q.push_back(desc_data);
      if (desc_data[30]) done_cnt++;
      if (desc_data[46]) bad_cnt++;
      {cid_bus, cid_dev, cid_fn} <= desc_data[87:72];
      ari_fn <= desc_data[79:72];
    end
  end
endmodule : cdb_user_model
`default_nettype wire

//--- verif/cdb_builder_test.sv
// Self-checking bench for the completion descriptor builder
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", nm, e, g); num_errors++; end end
module test_cdb_builder;
  logic        CLK = 1'h0;
  logic        RST_B = 1'h0;
  logic        CPL_VALID, CPL_TIMEOUT, CPL_ZERO_LEN, CPL_POISON, CPL_READY;
  logic [1:0]  CPL_KIND, CPL_ADDR_LO;
  logic [2:0]  CPL_STATUS, CPL_TC, CPL_ATTR;
  logic [7:0]  CPL_TAG;
  logic [15:0] CPL_REQ_ID, CPL_CMPL_ID;
  logic [10:0] CPL_LEN_DW;
  logic [12:0] CPL_BYTE_COUNT;
  logic        DESC_VALID, DESC_READY;
  logic [95:0] DESC_DATA;
  logic        stall = 1'h0;
  logic        slow = 1'h0;
  int          n = 0;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          exp_done = 0;
  int          exp_bad = 0;
  logic [7:0]  tg = 8'h5a;
  logic [95:0] exp_q[$];

  cdb_builder #(.DEPTH(4)) dut_u (.*);
  cdb_user_model user_u (.clk(CLK), .rst_b(RST_B), .stall(stall), .slow(slow),
    .desc_valid(DESC_VALID), .desc_ready(DESC_READY), .desc_data(DESC_DATA));

  always #25 CLK = ~CLK;

  // Offer one completion, hold it until taken, queue its expected descriptor
  task automatic snd(input logic t, input logic [1:0] k, input logic z, input logic [2:0] s,
                     input logic p, input logic [10:0] len, input logic [12:0] bc, input logic d);
    logic [3:0]  er;
    logic [10:0] dw;
    @(negedge CLK);
    n++;
    {CPL_VALID, CPL_TIMEOUT, CPL_KIND, CPL_ZERO_LEN, CPL_STATUS, CPL_POISON} = {1'h1, t, k, z, s, p};
    {CPL_REQ_ID, CPL_TAG, CPL_CMPL_ID} = {8'ha5, n[7:0], tg, n[7:0], 8'hc3};
    {CPL_TC, CPL_ATTR, CPL_LEN_DW, CPL_BYTE_COUNT} = {n[5:0], len, bc};
    er = t ? 4'h9 : p ? 4'h1 : (s != 3'h0) ? 4'h2 :
         (len == 11'h0 && k != 2'h1 && k != 2'h2 && !z) ? 4'h3 : 4'h0;
    dw = (k == 2'h1 || z) ? 11'h1 : (k == 2'h2) ? 11'h0 : len;
    exp_q.push_back(t ? {24'h0, CPL_TAG, CPL_REQ_ID, 32'h4000, 16'h9000} :
      {1'b0, CPL_ATTR, CPL_TC, 1'b0, CPL_CMPL_ID, CPL_TAG, CPL_REQ_ID, 1'b0, p, s, dw,
       1'b0, d, k == 2'h3, 13'h0, er, 12'h0});
    exp_done += exp_q[$][30];
    exp_bad  += exp_q[$][46];
    // A tag goes back into use only once its request has ended
    if (exp_q[$][30]) tg++;
    // Refused while ready is low: keep offering, bounded
    for (int i = 0; i < 200 && CPL_READY !== 1'h1; i++) @(negedge CLK);
    `CHK("taken", 1'h1, CPL_READY)
    @(negedge CLK);
    CPL_VALID = 1'h0;
  endtask : snd

  // Wait for all queued descriptors at the user side, then compare in order
  task automatic chk();
    logic [95:0] e, g;
    for (int i = 0; i < 400 && user_u.got_q.size() < exp_q.size(); i++) @(negedge CLK);
    `CHK("count", exp_q.size(), user_u.got_q.size())
    `CHK("done", exp_done, user_u.done_cnt)
    `CHK("poison", exp_bad, user_u.bad_cnt)
    while (exp_q.size() != 0 && user_u.got_q.size() != 0) begin
      e = exp_q.pop_front();
      g = user_u.got_q.pop_front();
      `CHK("desc", e, g)
    end
    exp_q.delete();
    user_u.got_q.delete();
  endtask : chk

  // A read split over packets: only the last ends it; largest count too
  task automatic t_split();
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h4, 13'h20, 1'h0);
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h4, 13'h10, 1'h1);
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h400, 13'h1000, 1'h1);
    // Skipped leading bytes shorten the first packet, so one byte remains
    CPL_ADDR_LO = 2'h2;
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h4, 13'hf, 1'h0);
    CPL_ADDR_LO = 2'h0;
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h1, 13'h1, 1'h1);
    chk();
  endtask : t_split

  // Counts fixed by the request kind, and a locked read
  task automatic t_kind();
    snd(1'h0, 2'h1, 1'h0, 3'h0, 1'h0, 11'h1, 13'h4, 1'h1);
    snd(1'h0, 2'h2, 1'h0, 3'h0, 1'h0, 11'h0, 13'h4, 1'h1);
    snd(1'h0, 2'h0, 1'h1, 3'h0, 1'h0, 11'h1, 13'h1, 1'h1);
    snd(1'h0, 2'h3, 1'h0, 3'h0, 1'h0, 11'h2, 13'h8, 1'h1);
    chk();
    `CHK("bus", n[7:0], user_u.cid_bus)
    `CHK("device", 5'h18, user_u.cid_dev)
    `CHK("function", 3'h3, user_u.cid_fn)
    `CHK("ari function", 8'hc3, user_u.ari_fn)
  endtask : t_kind

  // Every error status ends the request; poison alone does not; timeout
  task automatic t_err();
    logic [2:0] sts[3] = '{3'h1, 3'h2, 3'h4};
    foreach (sts[i]) snd(1'h0, 2'h0, 1'h0, sts[i], 1'h0, 11'h2, 13'h40, 1'h1);
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h0, 13'h40, 1'h1);
    snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h1, 11'h2, 13'h40, 1'h0);
    snd(1'h1, 2'h0, 1'h0, 3'h0, 1'h0, 11'h2, 13'h40, 1'h1);
    chk();
  endtask : t_err

  // Stall the user side until the path refuses, then drain it slowly
  task automatic t_fill();
    stall <= 1'h1;
    repeat (5) snd(1'h0, 2'h0, 1'h0, 3'h0, 1'h0, 11'h1, 13'h4, 1'h1);
    repeat (4) @(negedge CLK);
    `CHK("ready", 1'h0, CPL_READY)
    slow <= 1'h1;
    stall <= 1'h0;
    chk();
    `CHK("head", 1'h0, DESC_VALID)
    slow <= 1'h0;
  endtask : t_fill

  task automatic end_sim();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Main sequence; the address offset is zero outside the split scenario
  initial begin
    {CPL_VALID, CPL_TIMEOUT, CPL_KIND, CPL_ZERO_LEN, CPL_STATUS, CPL_POISON, CPL_ADDR_LO} = '0;
    {CPL_REQ_ID, CPL_TAG, CPL_CMPL_ID, CPL_TC, CPL_ATTR, CPL_LEN_DW, CPL_BYTE_COUNT} = '0;
    repeat (12) @(negedge CLK);
    RST_B = 1'h1;
    t_split();
    t_kind();
    t_err();
    t_fill();
    end_sim();
  end

  // Watchdog: the run needs about a hundred cycles, so this is ample
  initial begin
    #(50 * 20000);
    num_errors++;
    end_sim();
  end
endmodule : test_cdb_builder
`default_nettype wire
